// ---- hw/boost_supervisor_defines.vh ----
// Function
// - Integrator counts up on each boost step not met by a decrement tick
// - Integrator decrements at fixed interval
// - Integrator at limit sets overload fault
// - Integrator value readable by software
// - Voltage above limit sets overvoltage fault
// - Temperature above limit sets overtemp fault
// - Charging without voltage rise sets stall
// - Critical fault disables boost and injection
// - Re-enable only after software clears faults
// - Enable starts charging toward setpoint immediately
// - Keep regulating setpoint while enabled
// - Separate setpoints for inject and idle
// - External high voltage switches boost off
`ifndef BOOST_SUPERVISOR_DEFINES_VH
`define BOOST_SUPERVISOR_DEFINES_VH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK 12'h008
`define OFS_INTEG 12'h00c
`define OFS_SETPT 12'h010
`define OFS_LIMITS 12'h014
`define OFS_SENSE 12'h018
// Control fields
`define CTRL_BOOST_EN 0
`define CTRL_INJ_EN 1
// Status fault bit positions
`define FLT_STALL 0
`define FLT_OVERLOAD 1
`define FLT_OVERTEMP 2
`define FLT_OVERVOLT 3
// Reset values; RST_EXT_HV is the fixed external high-voltage threshold
`define RST_SETPT 32'h0000_0000
`define RST_LIMITS 32'h0055_009b
`define RST_EXT_HV 8'h06
// Timing
`define CLK_HZ 10000000
`define DEC_INTERVAL_US 100
`define DEC_CYCLES ((`CLK_HZ / 1000000) * `DEC_INTERVAL_US)
`define STALL_WINDOW_US 400
`define STALL_CYCLES ((`CLK_HZ / 1000000) * `STALL_WINDOW_US)
`define INTEG_LIMIT 16'hea60
`endif

// ---- hw/boost_supply_fault_supervisor.v ----
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "boost_supervisor_defines.vh"
module boost_supply_fault_supervisor #(
   parameter DEC_CYCLES = `DEC_CYCLES,
   parameter STALL_CYCLES = `STALL_CYCLES
) (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_ff,
   output reg pready_ff,
   output reg pslverr_ff,
   // Sense inputs, volts and degrees C
   input wire [7:0] cap_voltage,
   input wire [7:0] module_temp,
   input wire [7:0] external_hv_input,
   input wire injection_active,
   // Boost converter
   input wire boost_step,
   output reg boost_switch_on_ff,
   output reg inject_enable_ff,
   // Interrupt
   output reg irq_ff
);
   localparam ST_OFF = 3'b001; // Supply disabled
   localparam ST_CHARGE = 3'b010; // Below target, boosting
   localparam ST_HOLD = 3'b100; // At target, idling

   reg [1:0] ctrl_ff; // Enable bits from software
   reg [3:0] status_ff; // Sticky faults
   reg [3:0] mask_ff; // Interrupt mask
   reg [31:0] setpt_ff; // [7:0] idle, [15:8] inject
   reg [31:0] limits_ff; // [7:0] volt limit, [23:16] temp limit
   reg [2:0] state_ff; // Regulator state
   reg [2:0] nxt_state;
   reg [31:0] dec_cnt_ff; // Decrement interval counter
   reg dec_tick_ff; // One-cycle decrement pulse
   reg [31:0] stall_cnt_ff; // Cycles since last voltage rise
   reg [7:0] last_v_ff; // Voltage at last rise
   reg [31:0] nxt_rdata;
   reg nxt_err;
   wire [15:0] integ_count;
   wire integ_at_limit;
   wire wr_en;
   wire rd_en;
   wire [7:0] target_v;
   wire ext_hv_present;
   wire fault_any;
   wire stall_event;
   wire [3:0] fault_set;
   wire [3:0] clr_bits;
   wire run_ok;

   // Address decode for the write and status-clear paths; the read mux uses its own case
   function addr_hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         addr_hit = (a == ofs);
      end
   endfunction

   // Write lands on the edge that samples pready high
   assign wr_en = psel && penable && pwrite && pready_ff;
   // Read data launched one edge early so it stands with pready
   assign rd_en = psel && penable && !pwrite && !pready_ff;

   // Target tracks injection state
   assign target_v = injection_active ? setpt_ff[15:8] :
                     setpt_ff[7:0];
   assign ext_hv_present = external_hv_input > `RST_EXT_HV;
   assign fault_any = |status_ff;
   assign run_ok = ctrl_ff[`CTRL_BOOST_EN] && !fault_any && !ext_hv_present;

   // Stall: boosting, no rise seen in window
   assign stall_event = (state_ff == ST_CHARGE) &&
                        (stall_cnt_ff >= STALL_CYCLES - 1);

   assign fault_set[`FLT_STALL] = stall_event;
   assign fault_set[`FLT_OVERLOAD] = integ_at_limit;
   assign fault_set[`FLT_OVERTEMP] = module_temp > limits_ff[23:16];
   assign fault_set[`FLT_OVERVOLT] = cap_voltage > limits_ff[7:0];

   // Write-one-to-clear on status
   assign clr_bits = (wr_en && addr_hit(paddr, `OFS_STATUS)) ?
                     pwdata[3:0] : 4'h0;

   usage_integrator u_integ (
      .pclk(pclk),
      .presetn(presetn),
      .boost_step(boost_step),
      .dec_tick(dec_tick_ff),
      .count_ff(integ_count),
      .at_limit_ff(integ_at_limit)
   );

   // Fixed-interval divider, free of boost activity
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_cnt_ff <= 32'h0000_0000;
         dec_tick_ff <= 1'b0;
      end else if (dec_cnt_ff >= DEC_CYCLES - 1) begin
         dec_cnt_ff <= 32'h0000_0000;
         dec_tick_ff <= 1'b1;
      end else begin
         dec_cnt_ff <= dec_cnt_ff + 32'h0000_0001;
         dec_tick_ff <= 1'b0;
      end
   end

   // Rise watchdog; restarts whenever voltage climbs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_cnt_ff <= 32'h0000_0000;
         last_v_ff <= 8'h00;
      end else if (state_ff != ST_CHARGE || cap_voltage > last_v_ff) begin
         stall_cnt_ff <= 32'h0000_0000;
         last_v_ff <= cap_voltage;
      end else if (!stall_event) begin
         stall_cnt_ff <= stall_cnt_ff + 32'h0000_0001;
      end
   end

   // Regulator: hysteresis-free bang-bang on target
   always @* begin
      case (state_ff)
         ST_OFF: begin
            nxt_state = run_ok ? ST_CHARGE : ST_OFF;
         end
         ST_CHARGE: begin
            if (!run_ok) begin
               nxt_state = ST_OFF;
            end else if (cap_voltage >= target_v) begin
               nxt_state = ST_HOLD;
            end else begin
               nxt_state = ST_CHARGE;
            end
         end
         ST_HOLD: begin
            if (!run_ok) begin
               nxt_state = ST_OFF;
            end else if (cap_voltage < target_v) begin
               nxt_state = ST_CHARGE;
            end else begin
               nxt_state = ST_HOLD;
            end
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
   end

   // State and drive outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_OFF;
         boost_switch_on_ff <= 1'b0;
         inject_enable_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         boost_switch_on_ff <= (nxt_state == ST_CHARGE);
         // Injection held off until faults cleared
         inject_enable_ff <= ctrl_ff[`CTRL_INJ_EN] && !fault_any &&
                             !(|fault_set);
      end
   end

   // Sticky faults: set wins over clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= 4'h0;
      end else begin
         status_ff <= (status_ff & ~clr_bits) | fault_set;
      end
   end

   // Software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= 2'b00;
         mask_ff <= 4'h0;
         setpt_ff <= `RST_SETPT;
         limits_ff <= `RST_LIMITS;
      end else if (wr_en) begin
         if (addr_hit(paddr, `OFS_CTRL)) begin
            ctrl_ff <= pwdata[1:0];
         end
         if (addr_hit(paddr, `OFS_MASK)) begin
            mask_ff <= pwdata[3:0];
         end
         if (addr_hit(paddr, `OFS_SETPT)) begin
            setpt_ff <= {16'h0000, pwdata[15:0]};
         end
         if (addr_hit(paddr, `OFS_LIMITS)) begin
            limits_ff <= {8'h00, pwdata[23:16], 8'h00, pwdata[7:0]};
         end
      end
   end

   // Read mux; unmapped addresses answer with error
   always @* begin
      nxt_rdata = 32'h0000_0000;
      nxt_err = 1'b0;
      case (paddr)
         `OFS_CTRL: nxt_rdata = {30'h0, ctrl_ff};
         `OFS_STATUS: nxt_rdata = {28'h0, status_ff};
         `OFS_MASK: nxt_rdata = {28'h0, mask_ff};
         `OFS_INTEG: nxt_rdata = {16'h0, integ_count};
         `OFS_SETPT: nxt_rdata = setpt_ff;
         `OFS_LIMITS: nxt_rdata = limits_ff;
         `OFS_SENSE: nxt_rdata = {5'h0, state_ff, external_hv_input,
                                  module_temp, cap_voltage};
         default: nxt_err = 1'b1;
      endcase
   end

   // One wait state: pready one cycle into access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && nxt_err;
         if (rd_en) begin
            prdata_ff <= nxt_rdata;
         end
      end
   end

   // Level interrupt from masked sticky faults
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(((status_ff & ~clr_bits) | fault_set) & mask_ff);
      end
   end
endmodule // boost_supply_fault_supervisor

// ---- hw/usage_integrator.v ----
`timescale 1ns/1ps
`include "boost_supervisor_defines.vh"
module usage_integrator (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Events
   input wire boost_step,
   input wire dec_tick,
   // Result
   output reg [15:0] count_ff,
   output reg at_limit_ff
);
   reg [15:0] nxt_count; // Next integrator value

   // Up on boost, down on tick; both cancel out
   always @* begin
      nxt_count = count_ff;
      if (boost_step && !dec_tick) begin
         if (count_ff != 16'hffff) begin
            nxt_count = count_ff + 16'h0001;
         end
      end else if (dec_tick && !boost_step) begin
         if (count_ff != 16'h0000) begin
            nxt_count = count_ff - 16'h0001;
         end
      end
   end

   // Registered count and limit compare
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= 16'h0000;
         at_limit_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         at_limit_ff <= (nxt_count >= `INTEG_LIMIT);
      end
   end
endmodule // usage_integrator

// ---- test/boost_plant_model.sv ----
`timescale 1ns/1ps
module boost_plant_model (
   // Clock, reset, switch and bench controls
   input wire pclk,
   input wire presetn,
   input wire switch_on,
   input wire stall,
   input wire set_en,
   input wire burst,
   input wire [7:0] set_v,
   // Capacitor volts and step pulse
   output reg [7:0] cap_volt_ff,
   output reg step_ff
);
   reg [1:0] ph_ff; // Step phase
   wire tick = switch_on && (ph_ff == 2'h3);
   // Step every fourth cycle; a stall freezes the voltage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_volt_ff <= 8'h00;
         step_ff <= 1'b0;
         ph_ff <= 2'h0;
      end else begin
         ph_ff <= switch_on ? ph_ff + 2'h1 : 2'h0;
         // Burst forces a step every cycle to wind up the integrator
         step_ff <= tick || burst;
         if (set_en)
            cap_volt_ff <= set_v;
         else if (tick && !stall)
            cap_volt_ff <= cap_volt_ff + 8'h01;
      end
   end
endmodule // boost_plant_model

// ---- test/boost_sup_properties.sv ----
`timescale 1ns/1ps
module boost_sup_checker (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Bus
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready_ff,
   input wire pslverr_ff,
   // Sense inputs
   input wire [7:0] cap_voltage,
   input wire [7:0] module_temp,
   input wire [7:0] external_hv_input,
   // Supply outputs
   input wire boost_switch_on_ff,
   input wire inject_enable_ff,
   input wire irq_ff
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase still waiting
   sequence s_acc; psel && penable && !pready_ff; endsequence
   // Answer lasts one cycle only
   sequence s_ans; pready_ff ##1 !pready_ff; endsequence
   property p_ans; s_acc |=> s_ans; endproperty
   property p_cause; pready_ff |-> $past(psel && penable); endproperty
   property p_err; pslverr_ff |-> pready_ff; endproperty
   property p_volt;
      cap_voltage > 8'h9b |-> ##3 !boost_switch_on_ff && !inject_enable_ff;
   endproperty
   property p_temp; module_temp > 8'h55 |-> ##3 !inject_enable_ff; endproperty
   property p_ext; external_hv_input > 8'h06 [*3] |-> !boost_switch_on_ff;
   endproperty
   // Latched flags only drop after a software write
   property p_irq;
      $fell(irq_ff) |-> $past(psel && pwrite) || $past(psel && pwrite, 2);
   endproperty
   property p_rise;
      $rose(boost_switch_on_ff) |-> $past(cap_voltage) <= 8'h9b;
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer missing");
   a_cause: assert property (p_cause) else $error("answer without access");
   a_err: assert property (p_err) else $error("error outside answer");
   a_volt: assert property (p_volt) else $error("overvoltage ignored");
   a_temp: assert property (p_temp) else $error("overtemp ignored");
   a_ext: assert property (p_ext) else $error("boost on with ext");
   a_irq: assert property (p_irq) else $error("flag dropped alone");
   a_rise: assert property (p_rise) else $error("boost on too high");
endmodule // boost_sup_checker
bind boost_supply_fault_supervisor boost_sup_checker boost_sup_checker_inst (
   .pclk, .presetn, .psel, .penable, .pwrite, .pready_ff, .pslverr_ff,
   .cap_voltage, .module_temp, .external_hv_input, .boost_switch_on_ff,
   .inject_enable_ff, .irq_ff);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   reg pwrite = 1'b0, inj = 1'b0, stall = 1'b0, set_en = 1'b0, er;
   reg burst = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd, sp, tgt;
   reg [7:0] temp = 8'h19, ext = 8'h00, setv = 8'h00;
   wire [31:0] prdata_ff;
   wire [7:0] cap;
   wire pready_ff, pslverr_ff, step, sw, inj_en, irq_ff;
   integer mismatches = 0, n_checks = 0, cyc = 0, i, k;
   boost_supply_fault_supervisor #(.DEC_CYCLES(8), .STALL_CYCLES(16))
      boost_supply_fault_supervisor_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
      .pslverr_ff, .cap_voltage(cap), .module_temp(temp),
      .external_hv_input(ext), .injection_active(inj), .boost_step(step),
      .boost_switch_on_ff(sw), .inject_enable_ff(inj_en), .irq_ff);
   boost_plant_model boost_plant_model_inst (.pclk, .presetn,
      .switch_on(sw), .stall, .set_en, .burst, .set_v(setv),
      .cap_volt_ff(cap),
      .step_ff(step));
   always #50 pclk = ~pclk;
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Cycle ceiling against hangs
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         mismatches = mismatches + 1;
         final_report;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wt(input integer c);
      repeat (c) @(posedge pclk);
   endtask
   // Bus cycle: hold everything until pready is seen at an edge
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk) penable <= 1'b1;
         do @(posedge pclk); while (pready_ff !== 1'b1);
         rd = prdata_ff;
         er = pslverr_ff;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   // Fault causes: back-boost overvoltage, heat, stuck charge
   task cause(input integer c, input on);
      begin
         setv <= on ? 8'h9c : 8'h1e;
         set_en <= (c == 0);
         @(posedge pclk) set_en <= 1'b0;
         if (c == 1)
            temp <= on ? 8'h56 : 8'h19;
         if (c == 2)
            stall <= on;
      end
   endtask
   initial begin
      sp = $urandom(71);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, then an unmapped word
      for (i = 0; i < 6; i = i + 1) begin
         apb(0, 12'(i * 4), 32'h0);
         chk(rd, (i == 5) ? 32'h0055_009b : 32'h0);
      end
      apb(0, 12'h01c, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1, 12'h008, 32'hf);
      // Rising random targets, idle or injecting
      for (i = 0; i < 3; i = i + 1) begin
         sp = 20 * i + 10 + $urandom % 10;
         inj <= $urandom % 2;
         apb(1, 12'h010, {16'h0, sp[7:0] + 8'h05, sp[7:0]});
         tgt = inj ? sp + 5 : sp;
         apb(1, 12'h000, 32'h3);
         wt(2);
         chk(sw, 1);
         for (k = 0; sw && k < 400; k = k + 1)
            wt(1);
         wt(3);
         chk({cap >= tgt, sw}, 2'b10);
      end
      apb(0, 12'h00c, 32'h0);
      chk(rd != 0, 1);
      wt(1000);
      apb(0, 12'h00c, 32'h0);
      chk(rd, 32'h0);
      apb(1, 12'h010, 32'h6464);
      for (k = 0; k < 3; k = k + 1) begin
         cause(k, 1);
         wt(40);
         apb(0, 12'h004, 32'h0);
         tgt = 32'({k == 0, k == 1, 1'b0, k == 2});
         chk(rd, tgt);
         chk({irq_ff, sw, inj_en}, 3'b100);
         cause(k, 0);
         wt(5);
         apb(0, 12'h004, 32'h0);
         chk({rd[3:0], sw}, {tgt[3:0], 1'b0});
         apb(1, 12'h004, tgt);
         wt(3);
         chk({irq_ff, inj_en}, 2'b01);
      end
      ext <= 8'h07;
      wt(5);
      chk(sw, 0);
      ext <= 8'h06;
      wt(5);
      chk(sw, 1);
      // Overload: a step every cycle outruns the decrement
      burst <= 1'b1;
      for (k = 0; !irq_ff && k < 70000; k = k + 1)
         wt(1);
      apb(0, 12'h00c, 32'h0);
      chk(rd[15:0] >= 16'hea60, 1);
      apb(0, 12'h004, 32'h0);
      chk({rd[3:0], sw}, 5'h04);
      burst <= 1'b0;
      final_report;
   end
endmodule // testbench
